/* logic/pcpf_pkg.sv */
// Constants shared by the phase current phasor front end
package pcpf_pkg;
   // Channel structure
   localparam int PHASES = 3;              // Phases a, b, c
   localparam int SEL_W = 2;               // Multiplexer select width
   localparam int ADC_W = 12;              // Converter code width
   localparam int COMP_W = 14;             // Phasor component width in the message
   localparam int WIN = 9;                 // Samples i0..i8 in the one-cycle window
   localparam int SAMPLES_PER_CYCLE = 8;   // Samples per power-frequency cycle
   localparam int ACC_W = 26;              // Filter accumulator width
   // Timing
   localparam int MCLK_HZ = 25_000_000;    // System clock rate
   localparam int POWER_HZ = 50;           // Nominal power frequency
   localparam int SAMPLE_CYCLES = MCLK_HZ / (POWER_HZ * SAMPLES_PER_CYCLE);
   localparam int SETTLE_NS = 1000;        // Least multiplexer settling time
   localparam int SETTLE_CYCLES = (SETTLE_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
   localparam int GUARD_NS = 200;          // Least wait before trusting busy low
   localparam int GUARD_CYCLES = (GUARD_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CNT_W = 17;              // Width of the timing counters
   // Fixed-point filter constants
   localparam int INV_SQRT2_Q8 = 181;      // 1/sqrt2 scaled by 256
   localparam int UNIT_Q8 = 256;           // 1.0 scaled by 256
   localparam int HALF_Q8 = 128;           // 0.5 scaled by 256
   localparam int RND_SHIFT = 9;           // Quarter scaling, Q8 removal, one fraction bit kept
   localparam logic [ADC_W-1:0] CODE_MIN = 12'h000; // Offset-binary code limits
   localparam logic [ADC_W-1:0] CODE_MAX = 12'hfff;
   // Message layout, byte indices
   localparam int MSG_BYTES = 21;
   localparam int B_CMD = 0;               // Command byte
   localparam int B_TAG = 1;               // Own sample time tag, two bytes
   localparam int B_RTAG = 3;              // Last remote tag, two bytes
   localparam int B_DLY = 5;               // Arrival-to-sample delay, two bytes
   localparam int B_COMP = 7;              // Six components, eleven bytes
   localparam int B_STAT = 18;             // Status byte
   localparam int B_CRC = 19;              // CRC, high byte first
   localparam int IDX_W = 5;
   localparam int MSG_EVERY = 2;           // Samples per message
   localparam int TAG_W = 16;
   localparam int DLY_SHIFT = 2;           // Delay unit is 4 clocks
   // Check sequence
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   // Status byte bits
   localparam int ST_GAP = 0;
   localparam int ST_OVR = 1;
   localparam int ST_CLIP = 2;
   localparam int ST_RXOK = 3;
   // Acquisition states
   typedef enum logic [2:0] {
      PCPF_IDLE = 3'b000,
      PCPF_SETTLE = 3'b001,
      PCPF_START = 3'b010,
      PCPF_WAIT = 3'b011,
      PCPF_STORE = 3'b100
   } pcpf_state_type;
endpackage : pcpf_pkg

/* logic/pcpf_frontend.sv */
// Phase current sampling, one-cycle Fourier filter and 21-byte message packer
// Operation
// - eight samples per cycle, free-running clock
// - sampling never locked to remote end
// - phases multiplexed through SHA, 12-bit conversion
// - 30In maps to full scale, clip
// - nearest quantisation level, half lsb error
// - one-cycle Fourier, end samples halved in cosine
// - eight-point sine and cosine equations
// - component pair forms phasor at window origin
// - new phasor every sample, sliding window
// - each component carried in 14 bits
// - components plus fields form 21 bytes
// - link carries messages in HDLC frames
// - message carries tags and arrival-to-sample delay
// - receiver checks CRC, length, tag gaps
// - one message every two sample periods
`timescale 1ns/10ps
module pcpf_frontend #(
   parameter int unsigned SAMPLE_PERIOD_CYCLES = pcpf_pkg::SAMPLE_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Converter and sample-hold pins
   output logic [pcpf_pkg::SEL_W-1:0] mux_sel,
   output logic sha_hold,
   output logic adc_start,
   input wire logic adc_busy,
   input wire logic [pcpf_pkg::ADC_W-1:0] adc_data,
   // Phasor results
   output logic phasor_valid,
   output logic [pcpf_pkg::COMP_W-1:0] sine_component_a,
   output logic [pcpf_pkg::COMP_W-1:0] cosine_component_a,
   output logic [pcpf_pkg::COMP_W-1:0] sine_component_b,
   output logic [pcpf_pkg::COMP_W-1:0] cosine_component_b,
   output logic [pcpf_pkg::COMP_W-1:0] sine_component_c,
   output logic [pcpf_pkg::COMP_W-1:0] cosine_component_c,
   // Remote tag from the link receiver
   input wire logic rx_tag_valid,
   input wire logic [pcpf_pkg::TAG_W-1:0] rx_tag,
   // Command byte from the protection logic
   input wire logic [7:0] cmd_byte,
   // Message byte stream toward the framer
   output logic msg_valid,
   input wire logic msg_ready,
   output logic [7:0] msg_data,
   output logic msg_first,
   output logic msg_last
);
   import pcpf_pkg::*;

   localparam logic [CNT_W-1:0] SP_LAST = CNT_W'(SAMPLE_PERIOD_CYCLES - 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
   localparam logic [CNT_W-1:0] GUARD_LAST = CNT_W'(GUARD_CYCLES - 1);

   // Round a Q8 sum, scaled by a quarter, to a 14-bit component with one fraction bit
   function automatic logic signed [COMP_W-1:0] round_comp(input logic signed [ACC_W-1:0] acc);
      logic signed [ACC_W-1:0] tmp;
      tmp = acc + ACC_W'(1 <<< (RND_SHIFT - 1));
      return tmp[RND_SHIFT +: COMP_W];
   endfunction : round_comp

   // One byte through the CRC-16 shift register, MSB first
   function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
      logic [15:0] c;
      c = crc ^ {d, 8'h00};
      for (int k = 0; k < 8; k++) begin
         c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_byte

   // Sample clock
   logic [CNT_W-1:0] tick_cnt;             // Free-running sample period counter
   logic tick;                             // One-cycle sample instant
   // Converter handshake
   pcpf_state_type state;                  // Acquisition sequencer
   logic [CNT_W-1:0] wait_cnt;             // Settling and guard counter
   logic [SEL_W-1:0] ph;                   // Phase being converted
   logic busy_s1, busy_s2, busy_s3, busy_q;// Busy synchroniser and filtered level
   logic [ADC_W-1:0] dat_s1, dat_s2, dat_s3;// Data synchroniser
   logic signed [ADC_W-1:0] code;          // Signed sample
   logic store;                            // Sample written this cycle
   logic set_done;                         // All three phases stored
   // Window and filter
   logic signed [ADC_W-1:0] hist [PHASES][WIN]; // Newest sample at index 0
   logic signed [COMP_W-1:0] sin_w [PHASES], cos_w [PHASES]; // Live filter outputs
   logic signed [COMP_W-1:0] sin_r [PHASES], cos_r [PHASES]; // Registered component ports
   // Message fields
   logic [TAG_W-1:0] time_tag;             // Sample number of the current instant
   logic [TAG_W-1:0] rx_last;              // Last remote tag
   logic rx_seen;                          // A remote tag has arrived
   logic [DLY_SHIFT-1:0] dly_pre;
   logic [TAG_W-1:0] dly_cnt;              // Time since last remote arrival
   logic [TAG_W-1:0] dly_tick;             // Delay frozen at the sample instant
   logic every;                            // Alternates each phasor set
   logic gap_f, ovr_f, clip_f;             // Sticky status
   logic launch;
   logic [7:0] msg_buf [MSG_BYTES];
   logic [IDX_W-1:0] idx;
   logic [15:0] crc;
   logic accept;
   logic [8*MSG_BYTES-1:0] next_vec;

   // Sample instants come from our own counter only, so the far end's clock never steers it
   assign tick = (tick_cnt == SP_LAST);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      end
   end

   // Busy and data pins: a change counts once the second and third stages agree
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {busy_s1, busy_s2, busy_s3, busy_q} <= 4'h0;
         {dat_s1, dat_s2, dat_s3} <= '0;
      end else begin
         {busy_s3, busy_s2, busy_s1} <= {busy_s2, busy_s1, adc_busy};
         {dat_s3, dat_s2, dat_s1} <= {dat_s2, dat_s1, adc_data};
         if (busy_s2 == busy_s3) begin
            busy_q <= busy_s3;
         end
      end
   end

   // Offset-binary code to two's complement; the converter saturates at its
   // limits, and flipping the top bit keeps those limits at -2048 and +2047
   assign code = $signed({~dat_s3[ADC_W-1], dat_s3[ADC_W-2:0]});
   assign store = (state == PCPF_STORE) && (dat_s2 == dat_s3);
   assign set_done = store && (ph == SEL_W'(PHASES - 1));

   // Acquisition: one multiplexer, one SHA, one converter, phases in turn.
   // The period is far longer than three conversions, so a tick is never missed.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= PCPF_IDLE;
         wait_cnt <= '0;
         ph <= '0;
      end else begin
         case (state)
            PCPF_IDLE: begin
               if (tick) begin
                  ph <= '0;
                  wait_cnt <= SETTLE_LAST;
                  state <= PCPF_SETTLE;
               end
            end
            PCPF_SETTLE: begin     // Multiplexer output settles before hold
               if (wait_cnt == '0) begin
                  state <= PCPF_START;
               end else begin
                  wait_cnt <= wait_cnt - 1'b1;
               end
            end
            PCPF_START: begin      // Hold and start pulse together
               wait_cnt <= GUARD_LAST;
               state <= PCPF_WAIT;
            end
            PCPF_WAIT: begin       // Guard covers the synchroniser lag on busy
               if (wait_cnt != '0) begin
                  wait_cnt <= wait_cnt - 1'b1;
               end else if (!busy_q) begin
                  state <= PCPF_STORE;
               end
            end
            PCPF_STORE: begin
               if (store) begin
                  if (set_done) begin
                     state <= PCPF_IDLE;
                  end else begin
                     ph <= ph + 1'b1;
                     wait_cnt <= SETTLE_LAST;
                     state <= PCPF_SETTLE;
                  end
               end
            end
            default: begin
               state <= PCPF_IDLE;
            end
         endcase
      end
   end

   assign mux_sel = ph;
   assign sha_hold = (state == PCPF_START) || (state == PCPF_WAIT);
   assign adc_start = (state == PCPF_START);

   // Per-phase sliding window and eight-point Fourier filter
   genvar p;
   generate
      for (p = 0; p < PHASES; p++) begin : g_phase
         logic signed [ACC_W-1:0] i [WIN];  // i[n] is sample n, i[0] oldest
         logic signed [ACC_W-1:0] sin_acc, cos_acc;
         for (genvar n = 0; n < WIN; n++) begin : g_tap
            assign i[n] = ACC_W'(hist[p][WIN-1-n]);
         end
         // Window shifts at every stored sample so a phasor follows each instant
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               hist[p] <= '{default: '0};
            end else if (store && ph == SEL_W'(p)) begin
               hist[p][0] <= code;
               for (int k = 1; k < WIN; k++) begin
                  hist[p][k] <= hist[p][k-1];
               end
            end
         end
         // Sums kept in Q8 so 1/sqrt2 and the halves stay exact to the constant
         assign sin_acc = ACC_W'(INV_SQRT2_Q8) * (i[1] + i[3] - i[5] - i[7])
                        + ACC_W'(UNIT_Q8) * (i[2] - i[6]);
         assign cos_acc = ACC_W'(INV_SQRT2_Q8) * (i[1] - i[3] - i[5] + i[7])
                        + ACC_W'(HALF_Q8) * (i[0] - i[4] - i[4] + i[8]);
         // Result is amplitude*cos(phi), amplitude*sin(phi) at window start
         assign sin_w[p] = round_comp(sin_acc);
         assign cos_w[p] = round_comp(cos_acc);
      end
   endgenerate

   // Components latched one cycle after the third phase lands in its window
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         phasor_valid <= 1'b0;
         sin_r <= '{default: '0};
         cos_r <= '{default: '0};
      end else begin
         phasor_valid <= set_done;
         if (phasor_valid) begin
            sin_r <= sin_w;
            cos_r <= cos_w;
         end
      end
   end

   assign sine_component_a = sin_r[0];
   assign cosine_component_a = cos_r[0];
   assign sine_component_b = sin_r[1];
   assign cosine_component_b = cos_r[1];
   assign sine_component_c = sin_r[2];
   assign cosine_component_c = cos_r[2];

   // Time tags, remote tag and the arrival-to-sample delay
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {time_tag, rx_last, dly_cnt, dly_tick} <= '0;
         {rx_seen, dly_pre} <= '0;
      end else begin
         dly_pre <= dly_pre + 1'b1;
         if (tick) begin
            time_tag <= time_tag + 1'b1;
            dly_tick <= dly_cnt;
         end
         if (rx_tag_valid) begin
            rx_last <= rx_tag;
            rx_seen <= 1'b1;
            dly_cnt <= '0;
         end else if (dly_pre == '1 && dly_cnt != '1) begin
            dly_cnt <= dly_cnt + 1'b1; // Saturates instead of wrapping
         end
      end
   end

   // Sticky status, cleared when reported; a new event in that cycle wins
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {gap_f, ovr_f, clip_f, every} <= 4'h0;
      end else begin
         if (phasor_valid) begin
            every <= ~every;
         end
         // Remote end sends every second tag, so any other step means a loss
         if (rx_tag_valid && rx_seen && rx_tag != rx_last + TAG_W'(MSG_EVERY)) begin
            gap_f <= 1'b1;
         end else if (launch) begin
            gap_f <= 1'b0;
         end
         if (phasor_valid && every && msg_valid) begin
            ovr_f <= 1'b1;
         end else if (launch) begin
            ovr_f <= 1'b0;
         end
         if (store && (dat_s3 == CODE_MIN || dat_s3 == CODE_MAX)) begin
            clip_f <= 1'b1;
         end else if (launch) begin
            clip_f <= 1'b0;
         end
      end
   end

   // A message every second set; skipped if the previous one is still draining
   assign launch = phasor_valid && every && !msg_valid;

   // Message image, byte 0 first, CRC bytes filled on the way out
   assign next_vec = {cmd_byte, time_tag, rx_last, dly_tick,
                      sin_w[0], cos_w[0], sin_w[1], cos_w[1],
                      sin_w[2], cos_w[2], 4'h0,
                      4'h0, rx_seen, clip_f, ovr_f, gap_f,
                      16'h0000};

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         msg_buf <= '{default: '0};
      end else if (launch) begin
         for (int k = 0; k < MSG_BYTES; k++) begin
            msg_buf[k] <= next_vec[8*(MSG_BYTES-1-k) +: 8];
         end
      end
   end

   // Byte stream; the framer adds flags and stuffing around these 21 bytes
   assign accept = msg_valid && msg_ready;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {msg_valid, idx, crc} <= {1'b0, IDX_W'(0), CRC_INIT};
      end else if (launch) begin
         {msg_valid, idx, crc} <= {1'b1, IDX_W'(0), CRC_INIT};
      end else if (accept) begin
         if (idx < IDX_W'(B_CRC)) begin
            crc <= crc_byte(crc, msg_buf[idx]);
         end
         if (idx == IDX_W'(MSG_BYTES - 1)) begin
            msg_valid <= 1'b0;
         end else begin
            idx <= idx + 1'b1;
         end
      end
   end

   assign msg_data = (idx == IDX_W'(B_CRC)) ? crc[15:8] :
                     (idx > IDX_W'(B_CRC)) ? crc[7:0] : msg_buf[idx];
   assign msg_first = msg_valid && (idx == '0);
   assign msg_last = msg_valid && (idx == IDX_W'(MSG_BYTES - 1));
endmodule : pcpf_frontend

/* tb/pcpf_adc_model.sv */
// Converter and sample-hold stand-in that feeds known phase waves
`timescale 1ns/10ps
module pcpf_adc_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Converter pins
   input wire logic [pcpf_pkg::SEL_W-1:0] mux_sel,
   input wire logic sha_hold,
   input wire logic adc_start,
   output logic adc_busy,
   output logic [pcpf_pkg::ADC_W-1:0] adc_data
);
   import pcpf_pkg::*;
   localparam int BUSY_LEN = 12; // Conversion time in clocks, fixed so phasor spacing is too
   localparam int WAVE [8] = '{0, 1000, 1414, 1000, 0, -1000, -1414, -1000}; // One cycle
   int k [3]; // Conversions done per phase
   int left; // Busy clocks still to run
   logic [SEL_W-1:0] ph; // Phase latched at start
   // Signed value of phase p at sample n; phase c is doubled so that it clips
   function automatic int sig(input int p, input int n);
      int v;
      v = WAVE[(n + 3 * p) % 8] * (p == 2 ? 2 : 1);
      if (v > 2047) v = 2047; // Clip at the limits, never wrap
      if (v < -2048) v = -2048;
      return v;
   endfunction : sig
   // Busy rises after start; data toggles mid-conversion so no stale code looks valid
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         adc_busy <= 1'b0;
         adc_data <= 12'h000;
         left <= 0;
         ph <= '0;
         k <= '{0, 0, 0};
      end else if (adc_start && sha_hold) begin // No hold, no conversion
         ph <= mux_sel; // Held phase goes to the single converter
         adc_busy <= 1'b1;
         left <= BUSY_LEN;
      end else if (left > 0) begin
         left <= left - 1;
         if (left == 1) adc_busy <= 1'b0;
         if (left == 3) begin
            adc_data <= 12'(sig(ph, k[ph]) + 2048); // Exact level, offset binary
            k[ph] <= k[ph] + 1;
         end else if (left > 3) begin
            adc_data <= ~adc_data;
         end
      end
   end
endmodule : pcpf_adc_model

/* tb/pcpf_frontend_props.sv */
// Port assertions for the phasor front end
`timescale 1ns/10ps
module pcpf_frontend_props #(
   parameter int unsigned SAMPLE_PERIOD_CYCLES = pcpf_pkg::SAMPLE_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Converter side
   input wire logic [pcpf_pkg::SEL_W-1:0] mux_sel,
   input wire logic sha_hold,
   input wire logic adc_start,
   // Results and message stream
   input wire logic phasor_valid,
   input wire logic msg_valid,
   input wire logic msg_ready,
   input wire logic [7:0] msg_data,
   input wire logic msg_first,
   input wire logic msg_last
);
   import pcpf_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic [CNT_W-1:0] gap; // Clocks since the last phasor
   logic seen; // First phasor has nothing to measure against
   // Interval counter between phasors
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gap <= '0;
         seen <= 1'b0;
      end else if (phasor_valid) begin
         gap <= '0;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1'b1;
      end
   end
   sequence s_conv_go; adc_start && sha_hold; endsequence
   sequence s_last_taken; msg_valid && msg_ready && msg_last; endsequence
   property p_start_hold; adc_start |-> s_conv_go; endproperty
   property p_start_pulse; adc_start |=> !adc_start; endproperty
   property p_mux_steady; sha_hold && $past(sha_hold) |-> $stable(mux_sel); endproperty
   property p_mux_legal; mux_sel != 2'h3; endproperty
   property p_pv_pulse; phasor_valid |=> !phasor_valid; endproperty
   property p_pv_period; phasor_valid && seen |-> gap == SAMPLE_PERIOD_CYCLES - 1; endproperty
   property p_msg_hold;
      msg_valid && !msg_ready |=> msg_valid && $stable(msg_data) && $stable(msg_first)
         && $stable(msg_last);
   endproperty
   property p_first_last; msg_first |-> msg_valid && !msg_last; endproperty
   property p_launch; $rose(msg_valid) |-> $past(phasor_valid); endproperty
   property p_done; s_last_taken |=> !msg_valid; endproperty
   a_start_hold: assert property (p_start_hold)
      else $error("start without hold");
   a_start_pulse: assert property (p_start_pulse)
      else $error("start longer than one clock");
   a_mux_steady: assert property (p_mux_steady)
      else $error("phase select moved during hold");
   a_mux_legal: assert property (p_mux_legal)
      else $error("phase select out of range");
   a_pv_pulse: assert property (p_pv_pulse)
      else $error("phasor valid not a pulse");
   a_pv_period: assert property (p_pv_period)
      else $error("phasor spacing wrong");
   a_msg_hold: assert property (p_msg_hold)
      else $error("byte changed while stalled");
   a_first_last: assert property (p_first_last)
      else $error("first byte marked badly");
   a_launch: assert property (p_launch)
      else $error("message not launched by a phasor");
   a_done: assert property (p_done)
      else $error("message runs past its last byte");
endmodule : pcpf_frontend_props

bind pcpf_frontend pcpf_frontend_props #(.SAMPLE_PERIOD_CYCLES(SAMPLE_PERIOD_CYCLES))
   pcpf_frontend_props_inst (.mclk, .rst_b, .mux_sel, .sha_hold, .adc_start, .phasor_valid,
   .msg_valid, .msg_ready, .msg_data, .msg_first, .msg_last);

/* tb/pcpf_frontend_bench.sv */
// Self-checking bench for the phasor front end
`timescale 1ns/10ps
module pcpf_frontend_bench;
   import pcpf_pkg::*;
   localparam int PERIOD = 200; // Short sample period keeps the run brief
   // Clock, reset and design pins
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [SEL_W-1:0] mux_sel;
   logic sha_hold, adc_start, adc_busy, phasor_valid, msg_valid, msg_first, msg_last;
   logic [ADC_W-1:0] adc_data;
   logic [COMP_W-1:0] comp [6]; // Sine and cosine of a, b, c
   logic rx_tag_valid = 1'b0;
   logic [TAG_W-1:0] rx_tag = 16'h0000;
   logic [7:0] cmd_byte = 8'h00;
   logic [7:0] msg_data;
   logic msg_ready = 1'b1;
   logic stall = 1'b0; // Framer stalls every other clock when set
   logic [7:0] msg [MSG_BYTES]; // Last message accepted
   int errors = 0, checks = 0, pv_cnt = 0, msg_cnt = 0, idx = 0, launch = 0, prev = 0;
   pcpf_frontend #(.SAMPLE_PERIOD_CYCLES(PERIOD)) pcpf_frontend_inst (
      .mclk, .rst_b, .mux_sel, .sha_hold, .adc_start, .adc_busy, .adc_data, .phasor_valid,
      .sine_component_a(comp[0]), .cosine_component_a(comp[1]), .sine_component_b(comp[2]),
      .cosine_component_b(comp[3]), .sine_component_c(comp[4]), .cosine_component_c(comp[5]),
      .rx_tag_valid, .rx_tag, .cmd_byte, .msg_valid, .msg_ready, .msg_data, .msg_first,
      .msg_last);
   pcpf_adc_model pcpf_adc_model_inst (.mclk, .rst_b, .mux_sel, .sha_hold, .adc_start,
      .adc_busy, .adc_data);
   always #20 mclk = ~mclk;
   // Framer stand-in
   always @(posedge mclk) begin
      #1;
      msg_ready = stall ? ~msg_ready : 1'b1;
   end
   // Count phasors and gather accepted message bytes
   always @(posedge mclk) begin
      if (phasor_valid === 1'b1) pv_cnt <= pv_cnt + 1;
      if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
         msg[msg_first ? 0 : idx] <= msg_data;
         idx <= msg_first ? 1 : idx + 1;
         if (msg_first === 1'b1) launch <= pv_cnt;
         if (msg_last === 1'b1) begin
            ck("length", 16'(MSG_BYTES - 1), 16'(idx));
            msg_cnt <= msg_cnt + 1;
         end
      end
   end
   task automatic ck(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : ck
   task automatic final_report;
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   // One bounded clock of waiting; a hang ends the run
   task automatic step(inout int n);
      tick(1);
      n++;
      if (n > 4 * PERIOD) begin
         errors++;
         final_report();
      end
   endtask : step
   task automatic wait_pv;
      int n;
      n = 0;
      step(n);
      while (phasor_valid !== 1'b1) step(n);
   endtask : wait_pv
   // Filter result of phase p for window ending at sample n, from the same waves
   function automatic logic [13:0] comp_exp(input int p, input int n, input bit cosine);
      int s [9];
      int acc;
      for (int j = 0; j < 9; j++) s[j] = pcpf_adc_model_inst.sig(p, n - 8 + j);
      if (cosine) begin
         acc = INV_SQRT2_Q8 * (s[1] - s[3] - s[5] + s[7]) + HALF_Q8 * (s[0] - 2 * s[4] + s[8]);
      end else begin
         acc = INV_SQRT2_Q8 * (s[1] + s[3] - s[5] - s[7]) + UNIT_Q8 * (s[2] - s[6]);
      end
      return 14'((acc + 256) >>> RND_SHIFT);
   endfunction : comp_exp
   function automatic logic [15:0] crc_exp();
      logic [15:0] c;
      c = CRC_INIT;
      for (int b = 0; b < B_CRC; b++) begin
         for (int i = 7; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ msg[b][i]) ? CRC_POLY : 16'h0000);
         end
      end
      return c;
   endfunction : crc_exp
   // Outputs stay quiet while reset is held
   task automatic t_reset;
      ck("reset pins", 16'h0000, {8'h00, msg_valid, phasor_valid, adc_start,
         sha_hold, mux_sel, msg_first, msg_last});
      for (int q = 0; q < 6; q++) ck("reset component", 16'h0000, 16'(comp[q]));
   endtask : t_reset
   // Sliding window: a fresh, rotating phasor set at every sample
   task automatic t_phasors;
      int n;
      repeat (4) begin
         wait_pv();
         n = pv_cnt;
         tick(1);
         for (int q = 0; q < 6; q++) begin
            ck("component", 16'(comp_exp(q / 2, n, q[0])), 16'(comp[q]));
         end
      end
   endtask : t_phasors
   // Remote tag, then one whole message judged byte by byte
   task automatic t_message(input logic [15:0] tag, input logic [7:0] cmd, input bit slow,
         input logic [7:0] smask, input logic [7:0] sexp);
      int n, target;
      logic [87:0] pack;
      do wait_pv(); while (pv_cnt % 2 != 0);
      stall = slow;
      cmd_byte = cmd;
      rx_tag = tag;
      rx_tag_valid = 1'b1;
      tick(1);
      rx_tag_valid = 1'b0;
      target = msg_cnt + 1;
      n = 0;
      while (msg_cnt < target) step(n);
      stall = 1'b0;
      ck("launch parity", 16'h0000, 16'(launch % 2));
      if (prev != 0) ck("message spacing", 16'h0002, 16'(launch - prev));
      prev = launch;
      for (int q = 0; q < 6; q++) pack[87 - 14 * q -: 14] = comp_exp(q / 2, launch - 1, q[0]);
      pack[3:0] = 4'h0;
      for (int b = 0; b < 11; b++) begin
         ck("component byte", 16'(pack[87 - 8 * b -: 8]), 16'(msg[B_COMP + b]));
      end
      ck("command", 16'(cmd), 16'(msg[B_CMD]));
      ck("remote tag", tag, {msg[B_RTAG], msg[B_RTAG + 1]});
      ck("own tag", 16'(launch), {msg[B_TAG], msg[B_TAG + 1]});
      // Tag arrives in the phasor cycle, 133 clocks after the instant: 16 units of 4 remain
      ck("delay", 16'h0010, {msg[B_DLY], msg[B_DLY + 1]});
      ck("status", 16'(sexp), 16'(msg[B_STAT] & smask));
      ck("check sequence", crc_exp(), {msg[B_CRC], msg[B_CRC + 1]});
   endtask : t_message
   initial begin
      tick(4);
      t_reset();
      tick(4);
      rst_b = 1'b1;
      repeat (9) wait_pv();
      t_phasors();
      // Phase c clips on every fourth sample, so only the middle message reports it
      t_message(16'h1234, 8'ha5, 1'b1, 8'hff, 8'h08);
      t_message(16'h1236, 8'h5a, 1'b0, 8'hff, 8'h0c);
      t_message(16'h1300, 8'hc3, 1'b0, 8'hff, 8'h09);
      final_report();
   end
endmodule : pcpf_frontend_bench
